// >>> hdl/asder_pkg.sv
// Package: register map, field layout, reset values and threshold tables of the amplifier register bank
package asder_pkg;

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [7:0] ADDR_MODE_CTRL  = 8'h02;
  localparam logic [7:0] ADDR_ALC_CTRL1  = 8'h03;
  localparam logic [7:0] ADDR_ALC_CTRL2  = 8'h04;
  localparam logic [7:0] ADDR_POWER_DOWN = 8'h05;
  localparam logic [7:0] ADDR_FAULT      = 8'h06;
  localparam logic [7:0] ADDR_FAULT_CLR  = 8'h07;
  localparam logic [7:0] ADDR_SOFT_RST   = 8'h08;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0] RST_MODE_CTRL  = 8'h0c;
  localparam logic [7:0] RST_ALC_CTRL1  = 8'h2b;
  localparam logic [7:0] RST_ALC_CTRL2  = 8'h4b;
  localparam logic [7:0] RST_POWER_DOWN = 8'h03;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int MODE_OC_REC_BIT   = 3;
  localparam int MODE_OT_REC_BIT   = 2;
  localparam int MODE_USED_MSB     = 3;
  localparam int ALC2_MODE_BIT     = 4;
  localparam int ALC2_CODE_MSB     = 3;
  localparam int PD_RIGHT_BIT      = 1;
  localparam int PD_LEFT_BIT       = 0;
  localparam int FLT_OC_RIGHT_BIT  = 3;
  localparam int FLT_OC_LEFT_BIT   = 2;
  localparam int FLT_OT_WARN_BIT   = 1;
  localparam int FLT_OT_ERR_BIT    = 0;
  localparam int FAULT_SOURCES     = 4;

  // ********************************************************************
  // Threshold tables: percent of supply, and 8 ohm power in 10 mW units
  // ********************************************************************
  localparam logic [7:0] PCT_TABLE [16] = '{
    8'h40, 8'h42, 8'h43, 8'h45, 8'h46, 8'h48, 8'h4a, 8'h4c,
    8'h4e, 8'h50, 8'h53, 8'h55, 8'h58, 8'h5a, 8'h5d, 8'h60};
  localparam logic [7:0] PWR_TABLE [16] = '{
    8'h2a, 8'h2e, 8'h32, 8'h36, 8'h3b, 8'h3f, 8'h44, 8'h49,
    8'h4e, 8'h53, 8'h59, 8'h5f, 8'h64, 8'h6a, 8'h71, 8'h77};

endpackage

// >>> hdl/asder_fault_if.sv
// Interface: fault detector levels, recovery controls and fault state between register bank and fault tracker
`timescale 1ns/1ps
interface asder_fault_if #(parameter int N = 4);
  logic [N-1:0] det_raw;     // Detector pins, unsynchronised
  logic [N-1:0] recov_en;    // Automatic recovery per source
  logic         clear;       // Error clear write pulse
  logic [N-1:0] flag;        // Reported fault flags
  logic [N-1:0] hold;        // Fault state; overcurrent and thermal error bits force shutdown

  modport bank (output det_raw, output recov_en, output clear, input flag, input hold);
  modport track (input det_raw, input recov_en, input clear, output flag, output hold);
endinterface

// >>> hdl/asder_fault.sv
// Fault tracker: synchronises detector pins, keeps flags and latched fault state
`timescale 1ns/1ps
module asder_fault
  import asder_pkg::*;
#(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Fault carrier
  asder_fault_if.track f
);

  // ********************************************************************
  // Synchroniser and storage
  // ********************************************************************
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] flag;
  logic [N-1:0] latched;

  // Refuse an empty source list at elaboration
  if (N < 1) begin : g_bad_sources
    $error("asder_fault needs at least one source");
  end

  // Two stage synchroniser for the detector pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= f.det_raw;
      sync2 <= sync1;
    end
  end

  // Flags set while recovery control is on; clear write drops them, a new event wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag <= '0;
    end else begin
      flag <= ((f.clear ? '0 : flag) | (sync2 & f.recov_en));
    end
  end

  // Without autorecovery a fault stays latched until the host clears it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latched <= '0;
    end else begin
      latched <= ((f.clear ? '0 : latched) | (sync2 & ~f.recov_en));
    end
  end

  // With autorecovery the live detector alone holds the fault
  assign f.flag = flag;
  assign f.hold = latched | sync2;

endmodule

// >>> hdl/asder_regs.sv
// Control register bank of the stereo amplifier: shutdown, fault flags, error clear, soft reset, limiter threshold
`timescale 1ns/1ps
module asder_regs
  import asder_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Register port from the serial bus decoder
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  // Fault detector pins
  input  wire logic       oc_right_det,
  input  wire logic       oc_left_det,
  input  wire logic       ot_warn_det,
  input  wire logic       ot_err_det,
  // Amplifier controls
  output logic            right_amp_enable,
  output logic            left_amp_enable,
  output logic [7:0]      alc_ctrl1,
  output logic            alc_enable,
  output logic [1:0]      alc_compression,
  output logic            threshold_mode_select,
  output logic [3:0]      limiter_threshold_code,
  output logic [7:0]      limiter_threshold_value,
  output logic [1:0]      mix_select
);

  // ********************************************************************
  // Control registers
  // ********************************************************************
  logic [MODE_USED_MSB:0] mode_ctrl;
  logic [7:0]             alc_ctrl2;
  logic                   right_power_down;
  logic                   left_power_down;
  logic                   wr_mode;
  logic                   wr_alc1;
  logic                   wr_alc2;
  logic                   wr_pd;
  logic                   wr_clr;
  logic                   wr_srst;
  logic [7:0]             next_rdata;
  logic [7:0]             fault_flags;
  logic                   overcurrent_recovery_enable;
  logic                   thermal_recovery_enable;

  asder_fault_if #(.N(FAULT_SOURCES)) flt ();

  // Threshold lookup for both modes
  function automatic logic [7:0] asder_threshold(input logic fixed_power, input logic [3:0] code);
    logic [7:0] v;
    v = fixed_power ? PWR_TABLE[code] : PCT_TABLE[code];
    return v;
  endfunction

  // Write strobe decode
  always_comb begin
    wr_mode = 1'b0;
    wr_alc1 = 1'b0;
    wr_alc2 = 1'b0;
    wr_pd   = 1'b0;
    wr_clr  = 1'b0;
    wr_srst = 1'b0;
    if (reg_wr_en && reg_addr == ADDR_MODE_CTRL) begin
      wr_mode = 1'b1;
    end else if (reg_wr_en && reg_addr == ADDR_ALC_CTRL1) begin
      wr_alc1 = 1'b1;
    end else if (reg_wr_en && reg_addr == ADDR_ALC_CTRL2) begin
      wr_alc2 = 1'b1;
    end else if (reg_wr_en && reg_addr == ADDR_POWER_DOWN) begin
      wr_pd = 1'b1;
    end else if (reg_wr_en && reg_addr == ADDR_FAULT_CLR) begin
      wr_clr = 1'b1;
    end else if (reg_wr_en && reg_addr == ADDR_SOFT_RST) begin
      wr_srst = 1'b1;
    end
  end

  // Mode control: recovery enables and mixing
  always_ff @(posedge clk) begin
    if (!rst_b || wr_srst) begin
      mode_ctrl <= RST_MODE_CTRL[MODE_USED_MSB:0];
    end else if (wr_mode) begin
      mode_ctrl <= reg_wdata[MODE_USED_MSB:0];
    end
  end

  // Limiter timing register
  always_ff @(posedge clk) begin
    if (!rst_b || wr_srst) begin
      alc_ctrl1 <= RST_ALC_CTRL1;
    end else if (wr_alc1) begin
      alc_ctrl1 <= reg_wdata;
    end
  end

  // Limiter level register with threshold mode and code
  always_ff @(posedge clk) begin
    if (!rst_b || wr_srst) begin
      alc_ctrl2 <= RST_ALC_CTRL2;
    end else if (wr_alc2) begin
      alc_ctrl2 <= reg_wdata;
    end
  end

  // Channel power-down bits, both set after reset
  always_ff @(posedge clk) begin
    if (!rst_b || wr_srst) begin
      right_power_down <= RST_POWER_DOWN[PD_RIGHT_BIT];
      left_power_down  <= RST_POWER_DOWN[PD_LEFT_BIT];
    end else if (wr_pd) begin
      right_power_down <= reg_wdata[PD_RIGHT_BIT];
      left_power_down  <= reg_wdata[PD_LEFT_BIT];
    end
  end

  // ********************************************************************
  // Fault tracking
  // ********************************************************************
  assign overcurrent_recovery_enable = mode_ctrl[MODE_OC_REC_BIT];
  assign thermal_recovery_enable     = mode_ctrl[MODE_OT_REC_BIT];

  // Detector pins and recovery controls into the tracker
  always_comb begin
    flt.det_raw                   = '0;
    flt.recov_en                  = '0;
    flt.det_raw[FLT_OC_RIGHT_BIT] = oc_right_det;
    flt.det_raw[FLT_OC_LEFT_BIT]  = oc_left_det;
    flt.det_raw[FLT_OT_WARN_BIT]  = ot_warn_det;
    flt.det_raw[FLT_OT_ERR_BIT]   = ot_err_det;
    flt.recov_en[FLT_OC_RIGHT_BIT] = overcurrent_recovery_enable;
    flt.recov_en[FLT_OC_LEFT_BIT]  = overcurrent_recovery_enable;
    flt.recov_en[FLT_OT_WARN_BIT]  = thermal_recovery_enable;
    flt.recov_en[FLT_OT_ERR_BIT]   = thermal_recovery_enable;
    flt.clear                      = wr_clr;
  end

  asder_fault #(.N(FAULT_SOURCES)) u_fault (
    .clk   (clk),
    .rst_b (rst_b),
    .f     (flt)
  );

  assign fault_flags = {4'h0, flt.flag};

  // ********************************************************************
  // Amplifier control outputs
  // ********************************************************************
  // Channel enables combine power-down, overcurrent and thermal error state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      right_amp_enable <= 1'b0;
      left_amp_enable  <= 1'b0;
    end else begin
      right_amp_enable <= !right_power_down && !flt.hold[FLT_OC_RIGHT_BIT] && !flt.hold[FLT_OT_ERR_BIT];
      left_amp_enable  <= !left_power_down && !flt.hold[FLT_OC_LEFT_BIT] && !flt.hold[FLT_OT_ERR_BIT];
    end
  end

  // Threshold value: percent of supply or power in 10 mW units
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      limiter_threshold_value <= 8'h00;
    end else begin
      limiter_threshold_value <= asder_threshold(alc_ctrl2[ALC2_MODE_BIT], alc_ctrl2[ALC2_CODE_MSB:0]);
    end
  end

  assign alc_enable             = alc_ctrl2[7];
  assign alc_compression        = alc_ctrl2[6:5];
  assign threshold_mode_select  = alc_ctrl2[ALC2_MODE_BIT];
  assign limiter_threshold_code = alc_ctrl2[ALC2_CODE_MSB:0];
  assign mix_select             = mode_ctrl[1:0];

  // ********************************************************************
  // Read path
  // ********************************************************************
  // Read mux; write-only and unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == ADDR_MODE_CTRL) begin
      next_rdata = {4'h0, mode_ctrl};
    end else if (reg_addr == ADDR_ALC_CTRL1) begin
      next_rdata = alc_ctrl1;
    end else if (reg_addr == ADDR_ALC_CTRL2) begin
      next_rdata = alc_ctrl2;
    end else if (reg_addr == ADDR_POWER_DOWN) begin
      next_rdata = {6'h00, right_power_down, left_power_down};
    end else if (reg_addr == ADDR_FAULT) begin
      next_rdata = fault_flags;
    end else if (reg_addr == ADDR_FAULT_CLR || reg_addr == ADDR_SOFT_RST) begin
      next_rdata = 8'h00;
    end
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule

// >>> dv/asder_host.sv
// Partner model: host side of the register port, one byte per request
`timescale 1ns/1ps
module asder_host (
  // Clock
  input  wire logic       clk,
  // Request
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  // Answer
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid
);
  // Idle bus at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Write: strobe held across one rising edge, then lines scrambled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // Read: data only counts when the valid pulse is up
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    d         = reg_rd_valid ? reg_rdata : 8'hxx;
  endtask
endmodule

// >>> dv/asder_regs_assertions.sv
// Checker: port-level properties of the amplifier register bank
`timescale 1ns/1ps
module asder_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Register port
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rd_valid,
  // Amplifier controls
  input wire logic       right_amp_enable,
  input wire logic       left_amp_enable,
  input wire logic       threshold_mode_select,
  input wire logic [3:0] limiter_threshold_code,
  input wire logic [7:0] limiter_threshold_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ********************************************************************
  // Properties
  // ********************************************************************
  a_read_answer: assert property (reg_rd_valid == $past(reg_rd_en)) else $error("read valid misplaced");
  a_fault_upper_zero: assert property (reg_rd_en && reg_addr == 8'h06 |=> reg_rdata[7:4] == 4'h0)
    else $error("fault upper bits set");
  a_action_reads_zero: assert property (reg_rd_en && reg_addr inside {8'h07, 8'h08} |=> reg_rdata == 8'h00)
    else $error("action register read nonzero");
  a_right_power_down: assert property (reg_wr_en && reg_addr == 8'h05 && reg_wdata[1] |-> ##2 !right_amp_enable)
    else $error("right channel still running");
  a_left_power_down: assert property (reg_wr_en && reg_addr == 8'h05 && reg_wdata[0] |-> ##2 !left_amp_enable)
    else $error("left channel still running");
  a_reset_channels_off: assert property ($rose(rst_b) |-> (!right_amp_enable && !left_amp_enable) [*2])
    else $error("channel on after reset");
  a_supply_floor: assert property (!threshold_mode_select && limiter_threshold_code == 4'h0 &&
    $stable(limiter_threshold_code) && $stable(threshold_mode_select) |-> limiter_threshold_value == 8'h40)
    else $error("supply threshold floor wrong");
  a_supply_mid: assert property (!threshold_mode_select && limiter_threshold_code == 4'ha &&
    $stable(limiter_threshold_code) && $stable(threshold_mode_select) |-> limiter_threshold_value == 8'h53)
    else $error("supply threshold mid wrong");
  a_fixed_power: assert property (threshold_mode_select && limiter_threshold_code == 4'hb &&
    $stable(limiter_threshold_code) && $stable(threshold_mode_select) |-> limiter_threshold_value == 8'h5f)
    else $error("fixed power threshold wrong");

  // Main scenarios reached
  c_fault_read: cover property (reg_rd_en && reg_addr == 8'h06);
  c_soft_reset: cover property (reg_wr_en && reg_addr == 8'h08);
  c_right_off: cover property (left_amp_enable && !right_amp_enable);
endmodule

bind asder_regs asder_checker asder_checker_inst (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .right_amp_enable(right_amp_enable), .left_amp_enable(left_amp_enable),
  .threshold_mode_select(threshold_mode_select), .limiter_threshold_code(limiter_threshold_code),
  .limiter_threshold_value(limiter_threshold_value));

// >>> dv/asder_regs_bench.sv
// Testbench: reset values, shutdown, fault flags, error clear, soft reset, threshold tables
`timescale 1ns/1ps
module asder_regs_bench;
  logic       clk;
  logic       rst_b;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic       reg_rd_valid;
  logic       right_en;
  logic       left_en;
  logic       mode;
  logic [3:0] code;
  logic       alc_en;
  logic [1:0] comp;
  logic [1:0] mix;
  logic [7:0] alc1;
  logic [3:0] det;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] value;
  logic [1:0] en_exp [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
  int         err_total;
  int         samples_checked;

  // Clock, 100 ns period
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Device and host
  asder_regs asder_regs_inst (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .oc_right_det(det[3]), .oc_left_det(det[2]), .ot_warn_det(det[1]), .ot_err_det(det[0]),
    .right_amp_enable(right_en), .left_amp_enable(left_en), .alc_ctrl1(alc1), .alc_enable(alc_en),
    .alc_compression(comp), .threshold_mode_select(mode), .limiter_threshold_code(code),
    .limiter_threshold_value(value), .mix_select(mix));
  asder_host asder_host_inst (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    asder_host_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict;
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One detector pulse with automatic recovery on or off
  task automatic fault_run(input int i, input logic rec);
    det[i] = 1'b1;
    settle(5);
    chk({6'h0, right_en, left_en}, {6'h0, en_exp[i]});
    det[i] = 1'b0;
    settle(5);
    chk({6'h0, right_en, left_en}, rec ? 8'h03 : {6'h0, en_exp[i]});
    rchk(8'h06, rec ? 8'h01 << i : 8'h00);
    asder_host_inst.wr(8'h07, 8'h5a);
    settle(3);
    chk({6'h0, right_en, left_en}, 8'h03);
    rchk(8'h06, 8'h00);
  endtask

  // ********************************************************************
  // Sequence
  // ********************************************************************
  initial begin
    rst_b = 1'b0;
    det   = 4'h0;
    settle(2);
    rst_b = 1'b1;
    rchk(8'h05, 8'h03);
    rchk(8'h06, 8'h00);
    rchk(8'h02, 8'h0c);
    rchk(8'h04, 8'h4b);
    rchk(8'h07, 8'h00);
    rchk(8'h08, 8'h00);
    chk(value, 8'h55);
    asder_host_inst.wr(8'h05, 8'h02);
    settle(2);
    chk({6'h0, right_en, left_en}, 8'h01);
    asder_host_inst.wr(8'h05, 8'h01);
    settle(2);
    chk({6'h0, right_en, left_en}, 8'h02);
    asder_host_inst.wr(8'h05, 8'h00);
    asder_host_inst.wr(8'h06, 8'hff);
    rchk(8'h06, 8'h00);
    for (int i = 0; i < 4; i++) fault_run(i, 1'b1);
    asder_host_inst.wr(8'h02, 8'h00);
    for (int i = 0; i < 4; i++) fault_run(i, 1'b0);
    asder_host_inst.wr(8'h04, 8'h00);
    settle(2);
    chk(value, 8'h40);
    asder_host_inst.wr(8'h04, 8'h0a);
    settle(2);
    chk(value, 8'h53);
    asder_host_inst.wr(8'h04, 8'h1b);
    settle(2);
    chk(value, 8'h5f);
    asder_host_inst.wr(8'h03, 8'h3f);
    asder_host_inst.wr(8'h02, 8'h0d);
    rchk(8'h03, 8'h3f);
    rchk(8'h02, 8'h0d);
    chk(alc1, 8'h3f);
    chk({alc_en, comp, mode, code}, 8'h1b);
    chk({6'h0, mix}, 8'h01);
    asder_host_inst.wr(8'h08, 8'ha5);
    rchk(8'h05, 8'h03);
    rchk(8'h04, 8'h4b);
    rchk(8'h02, 8'h0c);
    rchk(8'h03, 8'h2b);
    chk(alc1, 8'h2b);
    chk({alc_en, comp, mode, code}, 8'h4b);
    chk({6'h0, mix}, 8'h00);
    // Flags survive a soft reset; a mid-run reset clears them and powers both channels down
    det = 4'h3;
    settle(5);
    rchk(8'h06, 8'h03);
    asder_host_inst.wr(8'h08, 8'h00);
    rchk(8'h06, 8'h03);
    det   = 4'h0;
    rst_b = 1'b0;
    settle(2);
    rst_b = 1'b1;
    chk({6'h0, right_en, left_en}, 8'h00);
    rchk(8'h06, 8'h00);
    rchk(8'h05, 8'h03);
    print_verdict;
  end

  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #1000000;
    err_total++;
    print_verdict;
  end
endmodule
